// file: include/ofd_pkg.sv
/*
  constants, field layouts and state codes of the operand field decoder.
  assumes a 32-bit apb register bus and a byte-wide opcode stream.
*/
package ofd_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_BASE_SRC  = 8'h04;
  localparam logic [7:0] ADDR_FRAME_DST = 8'h08;
  localparam logic [7:0] ADDR_COUNT     = 8'h0c;
  localparam logic [7:0] ADDR_FLAGS     = 8'h10;
  localparam logic [7:0] ADDR_STATUS    = 8'h14;
  localparam logic [7:0] ADDR_LOC       = 8'h18;
  localparam logic [7:0] ADDR_OPER      = 8'h1c;

  // control bits
  localparam int CTRL_IMM    = 0;
  localparam int CTRL_SEXT   = 1;
  localparam int CTRL_SHIFT  = 2;
  localparam int CTRL_STRING = 3;
  localparam int CTRL_SEGMOV = 4;
  localparam logic [4:0] CTRL_RESET = 5'h00;

  // processor_flag_word layout
  localparam int FLG_CARRY = 0;
  localparam int FLG_PAR   = 2;
  localparam int FLG_AUX   = 4;
  localparam int FLG_ZERO  = 6;
  localparam int FLG_SIGN  = 7;
  localparam int FLG_TRAP  = 8;
  localparam int FLG_INTEN = 9;
  localparam int FLG_DIR   = 10;
  localparam int FLG_OVF   = 11;
  localparam logic [15:0] FLAGS_MASK  = 16'h0fd5;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;

  // opcode and addressing byte fields
  localparam int OP_W_BIT = 0;
  localparam int OP_D_BIT = 1;
  localparam int MOD_HI = 7;
  localparam int MOD_LO = 6;
  localparam int REG_HI = 5;
  localparam int REG_LO = 3;
  localparam int RM_HI  = 2;
  localparam int RM_LO  = 0;
  localparam int SEG_HI = 4;
  localparam int SEG_LO = 3;

  localparam logic [1:0] MOD_NODISP = 2'h0;
  localparam logic [1:0] MOD_DISP8  = 2'h1;
  localparam logic [1:0] MOD_DISP16 = 2'h2;
  localparam logic [1:0] MOD_REG    = 2'h3;

  localparam logic [2:0] RM_BX_SI = 3'h0;
  localparam logic [2:0] RM_BX_DI = 3'h1;
  localparam logic [2:0] RM_BP_SI = 3'h2;
  localparam logic [2:0] RM_BP_DI = 3'h3;
  localparam logic [2:0] RM_SI    = 3'h4;
  localparam logic [2:0] RM_DI    = 3'h5;
  localparam logic [2:0] RM_BP    = 3'h6;
  localparam logic [2:0] RM_BX    = 3'h7;

  localparam logic [1:0] SEG_EXTRA = 2'h0;
  localparam logic [1:0] SEG_CODE  = 2'h1;
  localparam logic [1:0] SEG_STACK = 2'h2;
  localparam logic [1:0] SEG_DATA  = 2'h3;

  // prefix byte patterns
  localparam logic [7:0] SEG_PFX_MASK = 8'he7;
  localparam logic [7:0] SEG_PFX_VAL  = 8'h26;
  localparam logic [7:0] REP_PFX_MASK = 8'hfe;
  localparam logic [7:0] REP_PFX_VAL  = 8'hf2;

  localparam logic [1:0] LANE_LOW  = 2'h1;
  localparam logic [1:0] LANE_HIGH = 2'h2;
  localparam logic [1:0] LANE_WORD = 2'h3;
  localparam logic [7:0] SHIFT_ONE = 8'h01;

  typedef enum logic [6:0] {
    ST_IDLE    = 7'b0000001,
    ST_MODRM   = 7'b0000010,
    ST_DISP_LO = 7'b0000100,
    ST_DISP_HI = 7'b0001000,
    ST_IMM_LO  = 7'b0010000,
    ST_IMM_HI  = 7'b0100000,
    ST_DONE    = 7'b1000000
  } ofd_state_t;
endpackage : ofd_pkg

// file: hdl/ofd_reg_sel.sv
/*
  maps a register code and the width bit to a register index and lane.
  assumes the caller supplies stable codes; purely combinational.
*/
`timescale 1ns/1ps
module ofd_reg_sel
  import ofd_pkg::*;
#(
  parameter int CODE_W = 3
) (
  // selection
  input  wire logic [CODE_W-1:0] code,
  input  wire logic              wide,
  // result
  output logic      [CODE_W-1:0] idx,
  output logic      [1:0]        lane
);
  // ----------------------------------------------------------------
  // word codes name all eight, byte codes the halves of the first four
  // ----------------------------------------------------------------
  always_comb begin
    if (wide) begin
      idx  = code;
      lane = LANE_WORD;
    end else begin
      idx  = {1'b0, code[CODE_W-2:0]};
      lane = code[CODE_W-1] ? LANE_HIGH : LANE_LOW;
    end
  end
endmodule : ofd_reg_sel

// file: hdl/ofd_decoder.sv
/*
  operand field decoder: walks prefix, opcode, addressing, displacement
  and immediate bytes and resolves operands and the effective location.
  assumes an apb master on the register side and a byte stream with
  valid/ready from the prefetch queue, all on CLK_SYS.
*/
`timescale 1ns/1ps
module ofd_decoder
  import ofd_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        SRST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // opcode byte stream
  input  wire logic [7:0]  FETCH_BYTE,
  input  wire logic        FETCH_VALID,
  output logic             FETCH_READY,
  // decoded result
  output logic             DEC_DONE,
  output logic             DEC_REJECT,
  output logic [15:0]      EFF_LOC,
  output logic [15:0]      OPERAND,
  output logic [1:0]       SEG_SEL,
  output logic [2:0]       DEST_IDX,
  output logic [1:0]       DEST_LANE,
  output logic             DEST_IS_MEM,
  output logic [2:0]       SRC_IDX,
  output logic [1:0]       SRC_LANE,
  output logic             SRC_IS_MEM
);
  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  ofd_state_t  st_q, st_d;
  logic [4:0]  ctrl_q;
  logic [15:0] bx_q, si_q, bp_q, di_q, cx_q, flags_q;
  logic [7:0]  op_q, modrm_q;
  logic [15:0] disp_q, imm_q;
  logic        seg_ovr_q, rep_q, rep_z_q;
  logic [1:0]  seg_pfx_q;
  logic [31:0] prdata_q;
  logic        done_q, reject_q, rep_end_q;
  logic [15:0] loc_q, oper_q;
  logic [7:0]  shift_q;
  logic [1:0]  seg_out_q;
  logic [2:0]  dest_idx_q, src_idx_q;
  logic [1:0]  dest_lane_q, src_lane_q;
  logic        dest_mem_q, src_mem_q;

  logic        take, wr_en, rd_setup, addr_ok;
  logic        w_bit, s_bit, d_eff, is_mem, is_direct;
  logic        is_seg_pfx, is_rep_pfx, zf, cf, sf, of_bit;
  logic        below, above, less, greater;
  logic [1:0]  mod_f;
  logic [2:0]  reg_f, rm_f, reg_idx, rm_idx;
  logic [1:0]  reg_lane, rm_lane;
  logic [15:0] base_sum, loc_d;
  logic [7:0]  shift_d;
  ofd_state_t  after_disp;

  assign take        = FETCH_VALID & FETCH_READY;
  assign FETCH_READY = (st_q != ST_DONE);
  assign mod_f = modrm_q[MOD_HI:MOD_LO];
  assign reg_f = modrm_q[REG_HI:REG_LO];
  assign rm_f  = modrm_q[RM_HI:RM_LO];
  assign w_bit = op_q[OP_W_BIT];
  assign s_bit = ctrl_q[CTRL_SEXT] & op_q[OP_D_BIT];
  // sign-extend forms have no direction bit: register is the source
  assign d_eff = ~ctrl_q[CTRL_SEXT] & op_q[OP_D_BIT];
  assign is_mem    = ~ctrl_q[CTRL_STRING] & (mod_f != MOD_REG);
  assign is_direct = (mod_f == MOD_NODISP) && (rm_f == RM_BP);
  assign is_seg_pfx = (FETCH_BYTE & SEG_PFX_MASK) == SEG_PFX_VAL;
  assign is_rep_pfx = (FETCH_BYTE & REP_PFX_MASK) == REP_PFX_VAL;

  // ----------------------------------------------------------------
  // register selection for both fields
  // ----------------------------------------------------------------
  ofd_reg_sel #(.CODE_W(3)) u_reg_sel (
    .code (reg_f),
    .wide (w_bit),
    .idx  (reg_idx),
    .lane (reg_lane)
  );
  ofd_reg_sel #(.CODE_W(3)) u_rm_sel (
    .code (rm_f),
    .wide (w_bit),
    .idx  (rm_idx),
    .lane (rm_lane)
  );

  // ----------------------------------------------------------------
  // byte sequencing
  // ----------------------------------------------------------------
  always_comb begin
    after_disp = ctrl_q[CTRL_IMM] ? ST_IMM_LO : ST_DONE;
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: begin
        if (take && !is_seg_pfx && !is_rep_pfx) begin
          st_d = ctrl_q[CTRL_STRING] ? ST_DONE : ST_MODRM;
        end
      end
      ST_MODRM: begin
        if (take) begin
          if (FETCH_BYTE[MOD_HI:MOD_LO] == MOD_REG) begin
            st_d = after_disp;
          end else if (FETCH_BYTE[MOD_HI:MOD_LO] == MOD_NODISP &&
                       FETCH_BYTE[RM_HI:RM_LO] != RM_BP) begin
            st_d = after_disp;
          end else begin
            st_d = ST_DISP_LO;
          end
        end
      end
      ST_DISP_LO: begin
        if (take) begin
          st_d = (mod_f == MOD_DISP8) ? after_disp : ST_DISP_HI;
        end
      end
      ST_DISP_HI: begin
        if (take) begin
          st_d = after_disp;
        end
      end
      ST_IMM_LO: begin
        if (take) begin
          st_d = (w_bit && !s_bit) ? ST_IMM_HI : ST_DONE;
        end
      end
      ST_IMM_HI: begin
        if (take) begin
          st_d = ST_DONE;
        end
      end
      ST_DONE: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      st_q <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // instruction byte capture
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      op_q    <= 8'h00;
      modrm_q <= 8'h00;
      disp_q  <= 16'h0000;
      imm_q   <= 16'h0000;
    end else if (take) begin
      unique case (st_q)
        ST_IDLE: begin
          if (!is_seg_pfx && !is_rep_pfx) begin
            op_q    <= FETCH_BYTE;
            modrm_q <= 8'h00;
            disp_q  <= 16'h0000;
            imm_q   <= 16'h0000;
          end
        end
        ST_MODRM:   modrm_q <= FETCH_BYTE;
        ST_DISP_LO: disp_q  <= {{8{FETCH_BYTE[7]}}, FETCH_BYTE};
        ST_DISP_HI: disp_q[15:8] <= FETCH_BYTE;
        ST_IMM_LO: begin
          if (s_bit) begin
            imm_q <= {{8{FETCH_BYTE[7]}}, FETCH_BYTE};
          end else begin
            imm_q <= {8'h00, FETCH_BYTE};
          end
        end
        ST_IMM_HI:  imm_q[15:8] <= FETCH_BYTE;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // prefixes, cleared once their instruction completes
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      seg_ovr_q <= 1'b0;
      seg_pfx_q <= SEG_DATA;
      rep_q     <= 1'b0;
      rep_z_q   <= 1'b0;
    end else if (st_q == ST_DONE) begin
      seg_ovr_q <= 1'b0;
      rep_q     <= 1'b0;
    end else if (take && st_q == ST_IDLE) begin
      if (is_seg_pfx) begin
        seg_ovr_q <= 1'b1;
        seg_pfx_q <= FETCH_BYTE[SEG_HI:SEG_LO];
      end
      if (is_rep_pfx) begin
        rep_q   <= 1'b1;
        rep_z_q <= FETCH_BYTE[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // effective location, shift count and conditions
  // ----------------------------------------------------------------
  always_comb begin
    unique case (rm_f)
      RM_BX_SI: base_sum = 16'(bx_q + si_q);
      RM_BX_DI: base_sum = 16'(bx_q + di_q);
      RM_BP_SI: base_sum = 16'(bp_q + si_q);
      RM_BP_DI: base_sum = 16'(bp_q + di_q);
      RM_SI:    base_sum = si_q;
      RM_DI:    base_sum = di_q;
      RM_BP:    base_sum = is_direct ? 16'h0000 : bp_q;
      RM_BX:    base_sum = bx_q;
    endcase
    // wraps within the 64 KiB segment on purpose
    loc_d = 16'(base_sum + disp_q);
  end

  assign shift_d = op_q[OP_D_BIT] ? cx_q[7:0] : SHIFT_ONE;
  assign zf      = flags_q[FLG_ZERO];
  assign cf      = flags_q[FLG_CARRY];
  assign sf      = flags_q[FLG_SIGN];
  assign of_bit  = flags_q[FLG_OVF];
  assign below   = cf;
  assign above   = ~cf & ~zf;
  assign less    = sf ^ of_bit;
  assign greater = ~zf & ~(sf ^ of_bit);

  // ----------------------------------------------------------------
  // result registers, loaded in the done cycle
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      done_q      <= 1'b0;
      reject_q    <= 1'b0;
      rep_end_q   <= 1'b0;
      loc_q       <= 16'h0000;
      oper_q      <= 16'h0000;
      shift_q     <= 8'h00;
      seg_out_q   <= SEG_DATA;
      dest_idx_q  <= 3'h0;
      dest_lane_q <= LANE_WORD;
      dest_mem_q  <= 1'b0;
      src_idx_q   <= 3'h0;
      src_lane_q  <= LANE_WORD;
      src_mem_q   <= 1'b0;
    end else begin
      done_q <= (st_q == ST_DONE);
      if (st_q == ST_DONE) begin
        loc_q     <= loc_d;
        oper_q    <= imm_q;
        shift_q   <= ctrl_q[CTRL_SHIFT] ? shift_d : 8'h00;
        seg_out_q <= seg_ovr_q ? seg_pfx_q : SEG_DATA;
        // repetition ends once the zero flag differs from the prefix bit
        rep_end_q <= rep_q & ctrl_q[CTRL_STRING] & (zf != rep_z_q);
        reject_q  <= ctrl_q[CTRL_SEGMOV] & d_eff &
                     (reg_f[SEG_HI-SEG_LO:0] == SEG_CODE);
        if (d_eff) begin
          dest_idx_q  <= reg_idx;
          dest_lane_q <= reg_lane;
          dest_mem_q  <= 1'b0;
          src_idx_q   <= rm_idx;
          src_lane_q  <= rm_lane;
          src_mem_q   <= is_mem;
        end else begin
          dest_idx_q  <= rm_idx;
          dest_lane_q <= rm_lane;
          dest_mem_q  <= is_mem;
          src_idx_q   <= reg_idx;
          src_lane_q  <= reg_lane;
          src_mem_q   <= 1'b0;
        end
      end
    end
  end

  assign DEC_DONE    = done_q;
  assign DEC_REJECT  = reject_q;
  assign EFF_LOC     = loc_q;
  assign OPERAND     = oper_q;
  assign SEG_SEL     = seg_out_q;
  assign DEST_IDX    = dest_idx_q;
  assign DEST_LANE   = dest_lane_q;
  assign DEST_IS_MEM = dest_mem_q;
  assign SRC_IDX     = src_idx_q;
  assign SRC_LANE    = src_lane_q;
  assign SRC_IS_MEM  = src_mem_q;

  // ----------------------------------------------------------------
  // apb slave: zero wait states, error on unmapped address
  // ----------------------------------------------------------------
  assign addr_ok  = (PADDR[1:0] == 2'h0) && (PADDR <= ADDR_OPER);
  assign wr_en    = PSEL & PENABLE & PWRITE & addr_ok;
  assign rd_setup = PSEL & ~PENABLE;
  assign PREADY   = 1'b1;
  assign PSLVERR  = PSEL & PENABLE & ~addr_ok;
  assign PRDATA   = prdata_q;

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      ctrl_q  <= CTRL_RESET;
      bx_q    <= 16'h0000;
      si_q    <= 16'h0000;
      bp_q    <= 16'h0000;
      di_q    <= 16'h0000;
      cx_q    <= 16'h0000;
      flags_q <= FLAGS_RESET;
    end else if (wr_en) begin
      unique case (PADDR)
        ADDR_CTRL:      ctrl_q <= PWDATA[4:0];
        ADDR_BASE_SRC:  {si_q, bx_q} <= PWDATA;
        ADDR_FRAME_DST: {di_q, bp_q} <= PWDATA;
        ADDR_COUNT:     cx_q <= PWDATA[15:0];
        ADDR_FLAGS:     flags_q <= PWDATA[15:0] & FLAGS_MASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_setup) begin
      unique case (PADDR)
        ADDR_CTRL:      prdata_q <= {27'h0, ctrl_q};
        ADDR_BASE_SRC:  prdata_q <= {si_q, bx_q};
        ADDR_FRAME_DST: prdata_q <= {di_q, bp_q};
        ADDR_COUNT:     prdata_q <= {16'h0000, cx_q};
        ADDR_FLAGS:     prdata_q <= {16'h0000, flags_q};
        ADDR_STATUS:    prdata_q <= {16'h0000, rep_end_q, greater, less,
                                     above, below, reject_q, seg_out_q,
                                     shift_q};
        ADDR_LOC:       prdata_q <= {disp_q, loc_q};
        ADDR_OPER:      prdata_q <= {16'h0000, oper_q};
        default:        prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);

  a_imm_word: assert property (
    st_q == ST_IMM_HI && take |=> st_q == ST_DONE ##1
      OPERAND == {$past(FETCH_BYTE, 2), $past(imm_q[7:0], 1)})
    else $error("word immediate not assembled");
  a_imm_sext: assert property (
    st_q == ST_IMM_LO && take && s_bit && w_bit |=> st_q == ST_DONE &&
      imm_q == {{8{$past(FETCH_BYTE[7])}}, $past(FETCH_BYTE)})
    else $error("immediate byte not sign extended");
  a_shift_count: assert property (
    st_q == ST_DONE && ctrl_q[CTRL_SHIFT] |=>
      shift_q == ($past(op_q[OP_D_BIT]) ? $past(cx_q[7:0]) : SHIFT_ONE))
    else $error("shift count wrong");
  a_rep_end: assert property (
    st_q == ST_DONE && rep_q && ctrl_q[CTRL_STRING] |=>
      rep_end_q == ($past(zf) != $past(rep_z_q)))
    else $error("repeat end wrong");
  a_dest_dir: assert property (
    st_q == ST_DONE && d_eff |=> DEST_IDX == $past(reg_idx) && !DEST_IS_MEM)
    else $error("direction bit ignored");
  a_no_disp: assert property (
    st_q == ST_MODRM && take && FETCH_BYTE[MOD_HI:MOD_LO] == MOD_NODISP &&
      FETCH_BYTE[RM_HI:RM_LO] != RM_BP |=> st_q != ST_DISP_LO && disp_q == 16'h0000)
    else $error("displacement fetched for form 00");
  a_disp8: assert property (
    st_q == ST_DISP_LO && take && mod_f == MOD_DISP8 |=> st_q != ST_DISP_HI)
    else $error("extra displacement byte taken");
  a_disp16: assert property (
    st_q == ST_DISP_HI && take |=>
      disp_q == {$past(FETCH_BYTE), $past(disp_q[7:0])})
    else $error("displacement word misassembled");
  a_direct_loc: assert property (
    st_q == ST_DONE && is_direct && is_mem |=> EFF_LOC == $past(disp_q))
    else $error("direct location not displacement");
  a_cs_reject: assert property (
    st_q == ST_DONE && ctrl_q[CTRL_SEGMOV] && d_eff &&
      reg_f[SEG_HI-SEG_LO:0] == SEG_CODE |=> DEC_REJECT && DEC_DONE)
    else $error("code segment move not rejected");
endmodule : ofd_decoder

// file: bench/ofd_fetch_model.sv
/*
  prefetch queue model: offers queued bytes on a valid/ready stream.
  assumes the bench loads bytes through push() and paces it with slow.
*/
`timescale 1ns/1ps
module ofd_fetch_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // pacing
  input  wire logic       slow,
  // stream
  input  wire logic       rdy,
  output logic      [7:0] fbyte,
  output logic            fvalid
);
  logic [7:0] q[$];
  logic       gap_q;
  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask : push
  // an offer stands until taken; idle bytes toggle so stale data never repeats
  always @(posedge clk) begin
    if (srst) begin
      fvalid <= 1'b0;
      fbyte  <= 8'h00;
      gap_q  <= 1'b0;
    end else if (!fvalid || rdy) begin
      if (fvalid) void'(q.pop_front());
      gap_q <= ~gap_q;
      if (q.size() != 0 && !(slow && gap_q)) begin
        fvalid <= 1'b1;
        fbyte  <= q[0];
      end else begin
        fvalid <= 1'b0;
        fbyte  <= ~fbyte;
      end
    end
  end
endmodule : ofd_fetch_model

// file: bench/test_operand_field_decoder.sv
/*
  self-checking bench of the operand field decoder.
  assumes ofd_fetch_model on the stream side and a zero-wait apb slave.
*/
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module test_operand_field_decoder
  import ofd_pkg::*;
;
  logic        CLK_SYS = 1'b0;
  logic        SRST    = 1'b1;
  logic        PSEL    = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, slow = 1'b0;
  logic [7:0]  PADDR   = 8'h00, FETCH_BYTE;
  logic [31:0] PWDATA  = 32'h0, PRDATA, rdata;
  logic        PREADY, PSLVERR, FETCH_VALID, FETCH_READY, DEC_DONE, DEC_REJECT, rerr;
  logic        DEST_IS_MEM, SRC_IS_MEM;
  logic [15:0] EFF_LOC, OPERAND;
  logic [1:0]  SEG_SEL, DEST_LANE, SRC_LANE;
  logic [2:0]  DEST_IDX, SRC_IDX;
  int          num_errors = 0, tests_run = 0;

  always #12.5 CLK_SYS = ~CLK_SYS;

  ofd_decoder u_ofd_decoder (.CLK_SYS(CLK_SYS), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .FETCH_BYTE(FETCH_BYTE), .FETCH_VALID(FETCH_VALID),
    .FETCH_READY(FETCH_READY), .DEC_DONE(DEC_DONE), .DEC_REJECT(DEC_REJECT),
    .EFF_LOC(EFF_LOC), .OPERAND(OPERAND), .SEG_SEL(SEG_SEL), .DEST_IDX(DEST_IDX),
    .DEST_LANE(DEST_LANE), .DEST_IS_MEM(DEST_IS_MEM), .SRC_IDX(SRC_IDX),
    .SRC_LANE(SRC_LANE), .SRC_IS_MEM(SRC_IS_MEM));
  ofd_fetch_model u_ofd_fetch_model (.clk(CLK_SYS), .srst(SRST), .slow(slow),
    .rdy(FETCH_READY), .fbyte(FETCH_BYTE), .fvalid(FETCH_VALID));

  // ----------------------------------------------------------------
  // bus and stream helpers
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    PSEL    <= 1'b1;
    PWRITE  <= wr;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    do @(posedge CLK_SYS); while (PREADY !== 1'b1);
    rdata = PRDATA;
    rerr  = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task automatic run(input logic [4:0] ctrl, input logic [7:0] b[$]);
    int n;
    apb(1'b1, ADDR_CTRL, {27'h0, ctrl});
    foreach (b[i]) u_ofd_fetch_model.push(b[i]);
    n = 0;
    do begin
      @(negedge CLK_SYS);
      n++;
    end while (DEC_DONE !== 1'b1 && n < 40);
    `CHK("done", 1'b1, DEC_DONE)
  endtask : run

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    apb(1'b0, ADDR_FLAGS, 32'h0);
    `CHK("flags_rst", {16'h0, FLAGS_RESET}, rdata)
    apb(1'b1, ADDR_FLAGS, 32'hffff_ffff);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    `CHK("flags_mask", 32'h0000_0fd5, rdata)
    apb(1'b1, ADDR_LOC, 32'hffff_ffff);
    apb(1'b0, ADDR_LOC, 32'h0);
    `CHK("loc_ro", 32'h0, rdata)
    apb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 2'b10, {rerr, |rdata})
    apb(1'b1, ADDR_BASE_SRC, 32'h0200_1000);
    apb(1'b1, ADDR_FRAME_DST, 32'h0030_4000);
    apb(1'b1, ADDR_COUNT, 32'h0000_1234);
  endtask : t_regs
  task automatic t_imm_word;
    run(5'h03, '{8'h01, 8'h80, 8'h34, 8'h12, 8'h78, 8'h56});
    `CHK("ea_bx_si_d16", 16'h2434, EFF_LOC)
    `CHK("imm_word", 16'h5678, OPERAND)
    `CHK("mem_dest", 2'b10, {DEST_IS_MEM, SRC_IS_MEM})
    `CHK("seg_default", SEG_DATA, SEG_SEL)
  endtask : t_imm_word
  task automatic t_imm_sext;
    slow = 1'b1;
    run(5'h03, '{8'h03, 8'h46, 8'h80, 8'h9c});
    slow = 1'b0;
    `CHK("ea_bp_d8", 16'h3f80, EFF_LOC)
    `CHK("imm_sext", 16'hff9c, OPERAND)
  endtask : t_imm_sext
  task automatic t_direct;
    run(5'h00, '{8'h36, 8'h00, 8'h06, 8'hcd, 8'hab});
    `CHK("ea_direct", 16'habcd, EFF_LOC)
    `CHK("seg_override", SEG_STACK, SEG_SEL)
    run(5'h00, '{8'h00, 8'h04});
    `CHK("ea_si_nodisp", 16'h0200, EFF_LOC)
    `CHK("seg_restored", SEG_DATA, SEG_SEL)
  endtask : t_direct
  task automatic t_regsel;
    run(5'h00, '{8'h02, 8'he1});
    `CHK("dst_byte", {3'h0, LANE_HIGH, 1'b0}, {DEST_IDX, DEST_LANE, DEST_IS_MEM})
    `CHK("src_byte", {3'h1, LANE_LOW, 1'b0}, {SRC_IDX, SRC_LANE, SRC_IS_MEM})
    run(5'h00, '{8'h03, 8'he1});
    `CHK("dst_word", {3'h4, LANE_WORD}, {DEST_IDX, DEST_LANE})
    `CHK("src_word", {3'h1, LANE_WORD}, {SRC_IDX, SRC_LANE})
  endtask : t_regsel
  task automatic t_segmove;
    run(5'h10, '{8'h02, 8'hc8});
    `CHK("reject_code", 1'b1, DEC_REJECT)
    run(5'h10, '{8'h02, 8'hd8});
    `CHK("accept_data", 1'b0, DEC_REJECT)
    run(5'h10, '{8'h02, 8'he8});
    `CHK("reject_code_hi", 1'b1, DEC_REJECT)
  endtask : t_segmove
  task automatic t_shift;
    run(5'h04, '{8'h03, 8'hc0});
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("count_reg", 8'h34, rdata[7:0])
    run(5'h04, '{8'h01, 8'hc0});
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("count_one", SHIFT_ONE, rdata[7:0])
  endtask : t_shift
  task automatic t_repeat;
    apb(1'b1, ADDR_FLAGS, 32'h0);
    run(5'h08, '{8'hf3, 8'ha6});
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("rep_end", 1'b1, rdata[15])
    `CHK("cond_clear", 4'ha, rdata[14:11])
    apb(1'b1, ADDR_FLAGS, 32'h0000_0040);
    run(5'h08, '{8'hf3, 8'ha6});
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("rep_go", 1'b0, rdata[15])
    `CHK("cond_zero", 4'h0, rdata[14:11])
    apb(1'b1, ADDR_FLAGS, 32'h0000_0081);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("cond_carry_sign", 4'h5, rdata[14:11])
  endtask : t_repeat

  // ----------------------------------------------------------------
  // sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (8) @(posedge CLK_SYS);
    SRST <= 1'b0;
    t_regs();
    t_imm_word();
    t_imm_sext();
    t_direct();
    t_regsel();
    t_segmove();
    t_shift();
    t_repeat();
    finish_test();
  end
  initial begin
    #100000;
    num_errors++;
    finish_test();
  end
endmodule : test_operand_field_decoder
